// ==== design/srh_top.sv ====
// sense and release handler: release and sense commands, per-initiator sense
// records, sense byte stream and drive serial field filler
// assumes a protocol engine that hands over decoded command blocks, reports
// errors per initiator and drains the byte stream; registers over AXI4-Lite
//
// Contract
// - opcode 17h releases only issuer's own reservations
// - releasing unreserved elements raises no error
// - on-behalf bit releases for named device
// - element bit 0 all, 1 one reservation
// - opcode 03h returns requester's stored sense record
// - eight independent records indexed by selection identity
// - next command or resets clear records
// - unidentified initiators share one sense slot
// - check condition or bus-free error makes sense
// - wrong unit returns key 5, 25h, 00h
// - nothing pending returns key 0, 00h, 00h
// - latest error overwrites earlier stored sense
// - eighteen byte record, zero length sends nothing
// - send smaller of allocation and available bytes
// - response code 70h when pending, else 0
// - valid bit and information field always zero
// - serial left justified, fill 00h or 20h
// - every descriptor serial field has common width
// - additional length byte always reads 0Ah
// - key specific valid only for illegal request
// - aborted command reported with sense key 11
`timescale 1ns/1ps
module srh_top (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // command block from the protocol engine
    input wire logic i_cmd_valid,
    input wire srh_pkg::srh_cmd_t i_cmd,
    output logic o_cmd_ready,
    // command completion
    output logic o_status_valid,
    output logic [7:0] o_status,
    // error reports raised while a command runs
    input wire logic i_err_valid,
    input wire srh_pkg::srh_err_t i_err,
    // unexpected bus-free termination
    input wire logic i_bus_free_valid,
    input wire logic [2:0] i_bus_free_initiator,
    input wire logic i_bus_free_id_known,
    // resets: message from logic, bus reset from the pin
    input wire logic i_device_reset_msg,
    input wire logic i_bus_reset,
    // serial field request for an element descriptor
    input wire logic i_desc_start,
    output logic o_desc_ready,
    // outgoing byte stream
    output logic o_byte_valid,
    output logic [7:0] o_byte_data,
    output logic o_byte_last,
    input wire logic i_byte_ready,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import srh_pkg::*;

    // ----
    // functions
    // ----
    // unidentified initiators all land in the shared slot
    function automatic logic [3:0] slot_of(input logic [2:0] id, input logic known);
        slot_of = known ? {1'b0, id} : SHARED_SLOT;
    endfunction

    function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        merge_strb = r;
    endfunction

    function automatic logic [7:0] sense_byte(input srh_sense_t s, input logic [5:0] idx);
        logic [7:0] r;
        r = 8'h00;
        case (idx)
            SB_RESP: r = s.pending ? RESP_CURRENT : RESP_NONE;
            SB_KEY: r = {4'h0, s.key};
            SB_ADD_LEN: r = ADD_SENSE_LEN;
            SB_CODE: r = s.additional_code;
            SB_QUAL: r = s.additional_qualifier;
            SB_SKS0: r = {(s.key == KEY_ILLEGAL), s.sks.cd, 2'b00, s.sks.bpv, s.sks.bit_ptr};
            SB_SKS1: r = s.sks.field_ptr[15:8];
            SB_SKS2: r = s.sks.field_ptr[7:0];
            default: r = 8'h00;
        endcase
        sense_byte = r;
    endfunction

    // ----
    // declarations
    // ----
    srh_state_t state;
    srh_sense_t sense_mem [NUM_SLOTS];
    srh_sense_t snap;
    srh_resv_t resv [NUM_RESV];
    logic [31:0] ctrl_reg;
    logic [31:0] serial_cfg;
    logic [31:0] serial_buf [4];
    logic [5:0] idx;
    logic [5:0] total;
    logic bus_rst_s1, bus_rst_s2, bus_rst_s3, bus_rst_lvl;
    logic cmd_take, desc_take, byte_take, wr_take, rd_take;
    logic is_sense, is_release, wrong_lun, clear_all;
    logic [3:0] cmd_slot;
    logic [2:0] cfg_lun;
    logic [5:0] ser_len, ser_width;
    logic [5:0] next_total;
    logic [7:0] fill_byte;
    srh_sense_t next_snap;

    assign cfg_lun = ctrl_reg[CTRL_LUN_LSB +: 3];
    assign ser_len = {1'b0, serial_cfg[SER_LEN_LSB +: 5]};
    assign ser_width = serial_cfg[SER_WIDTH_LSB +: 6];
    assign fill_byte = ctrl_reg[CTRL_FILL_BIT] ? FILL_SPACE : FILL_ZERO;

    function automatic logic [7:0] serial_byte(input logic [5:0] i);
        logic [7:0] r;
        r = fill_byte;
        if (i < ser_len) begin
            r = serial_buf[i[3:2]][i[1:0]*8 +: 8];
        end
        serial_byte = r;
    endfunction

    // ----
    // bus reset pin synchroniser
    // ----
    // level moves only when stages two and three agree
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_rst_s1 <= 1'b0;
            bus_rst_s2 <= 1'b0;
            bus_rst_s3 <= 1'b0;
            bus_rst_lvl <= 1'b0;
        end else begin
            bus_rst_s1 <= i_bus_reset;
            bus_rst_s2 <= bus_rst_s1;
            bus_rst_s3 <= bus_rst_s2;
            if (bus_rst_s2 == bus_rst_s3) begin
                bus_rst_lvl <= bus_rst_s3;
            end
        end
    end

    // ----
    // command decode
    // ----
    assign o_cmd_ready = (state == ST_IDLE);
    assign o_desc_ready = (state == ST_IDLE) && !i_cmd_valid;
    assign cmd_take = i_cmd_valid && o_cmd_ready;
    assign desc_take = i_desc_start && o_desc_ready;
    assign byte_take = o_byte_valid && i_byte_ready;
    assign is_sense = (i_cmd.opcode == OP_SENSE);
    assign is_release = (i_cmd.opcode == OP_RELEASE);
    assign wrong_lun = (i_cmd.byte1[CDB_LUN_LSB +: 3] != cfg_lun);
    assign cmd_slot = slot_of(i_cmd.initiator, i_cmd.id_known);
    assign clear_all = i_device_reset_msg || bus_rst_lvl;
    // bytes sent are the smaller of request and record
    assign next_total = (i_cmd.alloc_len < {2'b00, SENSE_LEN}) ? i_cmd.alloc_len[5:0] : SENSE_LEN;

    // record returned for a sense request, chosen at acceptance
    always_comb begin
        next_snap = '0;
        if (wrong_lun) begin
            next_snap.pending = 1'b1;
            next_snap.key = KEY_ILLEGAL;
            next_snap.additional_code = CODE_NO_LUN;
            next_snap.additional_qualifier = CODE_ZERO;
        end else if (sense_mem[cmd_slot].pending) begin
            next_snap = sense_mem[cmd_slot];
        end
    end

    // ----
    // sense records
    // ----
    // clears first, new events last, so an event in
    // the clearing cycle survives
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int s = 0; s < NUM_SLOTS; s++) begin
                sense_mem[s] <= '0;
            end
        end else begin
            if (clear_all) begin
                for (int s = 0; s < NUM_SLOTS; s++) begin
                    sense_mem[s] <= '0;
                end
            end
            // a sense request to a foreign unit leaves the real record alone
            if (cmd_take && !(is_sense && wrong_lun)) begin
                sense_mem[cmd_slot] <= '0;
            end
            if (i_bus_free_valid) begin
                sense_mem[slot_of(i_bus_free_initiator, i_bus_free_id_known)] <=
                    '{pending: 1'b1, key: KEY_ABORTED, additional_code: CODE_ZERO,
                      additional_qualifier: CODE_ZERO, sks: '0};
            end
            if (i_err_valid) begin
                sense_mem[slot_of(i_err.initiator, i_err.id_known)] <=
                    '{pending: 1'b1, key: i_err.key, additional_code: i_err.additional_code,
                      additional_qualifier: i_err.additional_qualifier, sks: i_err.sks};
            end
        end
    end

    // ----
    // reservation table
    // ----
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int r = 0; r < NUM_RESV; r++) begin
                resv[r] <= '0;
            end
        end else begin
            if (cmd_take && is_release && !wrong_lun) begin
                for (int r = 0; r < NUM_RESV; r++) begin
                    // own entries only; on-behalf ones only for the named device
                    if (resv[r].valid && resv[r].owner == i_cmd.initiator && i_cmd.id_known
                        && resv[r].on_behalf_flag == i_cmd.byte1[CDB_ON_BEHALF_BIT]
                        && (!i_cmd.byte1[CDB_ON_BEHALF_BIT]
                            || resv[r].on_behalf_id == i_cmd.byte1[CDB_ON_BEHALF_ID_LSB +: 3])
                        && (!i_cmd.byte1[CDB_ELEMENT_BIT] || i_cmd.byte2 == 8'(r))) begin
                        resv[r].valid <= 1'b0;
                    end
                end
            end
            if (wr_take && s_axi_awaddr == ADDR_RESV) begin
                resv[s_axi_wdata[RESV_IDX_LSB +: 3]] <= '{valid: s_axi_wdata[RESV_VALID_BIT],
                    owner: s_axi_wdata[RESV_OWNER_LSB +: 3], on_behalf_flag: s_axi_wdata[RESV_OB_BIT],
                    on_behalf_id: s_axi_wdata[RESV_OB_ID_LSB +: 3]};
            end
        end
    end

    // ----
    // sequencer
    // ----
    // status leaves one cycle after the last byte is taken, or one cycle after the record update at acceptance when no bytes are sent
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cmd_take && is_sense) begin
                        state <= (next_total == 6'h00) ? ST_STATUS : ST_SENSE;
                    end else if (cmd_take && is_release) begin
                        state <= ST_STATUS;
                    end else if (desc_take && ser_width != 6'h00) begin
                        state <= ST_SERIAL;
                    end
                end
                ST_SENSE: begin
                    if (byte_take && o_byte_last) begin
                        state <= ST_STATUS;
                    end
                end
                ST_SERIAL: begin
                    if (byte_take && o_byte_last) begin
                        state <= ST_IDLE;
                    end
                end
                ST_STATUS: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // good status; errors in the sense path itself are not reported here
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_status_valid <= 1'b0;
            o_status <= STATUS_GOOD;
        end else begin
            o_status_valid <= (state == ST_STATUS);
            o_status <= STATUS_GOOD;
        end
    end

    // ----
    // byte stream
    // ----
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            snap <= '0;
            idx <= 6'h00;
            total <= 6'h00;
            o_byte_valid <= 1'b0;
            o_byte_data <= 8'h00;
            o_byte_last <= 1'b0;
        end else begin
            if (cmd_take && is_sense && next_total != 6'h00) begin
                snap <= next_snap;
                idx <= 6'h00;
                total <= next_total;
                o_byte_valid <= 1'b1;
                o_byte_data <= sense_byte(next_snap, 6'h00);
                o_byte_last <= (next_total == 6'h01);
            end else if (desc_take && ser_width != 6'h00) begin
                idx <= 6'h00;
                total <= ser_width;
                o_byte_valid <= 1'b1;
                o_byte_data <= serial_byte(6'h00);
                o_byte_last <= (ser_width == 6'h01);
            end else if (byte_take) begin
                if (o_byte_last) begin
                    o_byte_valid <= 1'b0;
                    o_byte_last <= 1'b0;
                end else begin
                    idx <= idx + 6'h01;
                    o_byte_data <= (state == ST_SENSE) ? sense_byte(snap, idx + 6'h01)
                                                       : serial_byte(idx + 6'h01);
                    o_byte_last <= (idx + 6'h02 == total);
                end
            end
        end
    end

    // ----
    // AXI4-Lite slave
    // ----
    // address and data are taken together; a lone channel waits for its mate
    assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_wready = s_axi_awready;
    assign wr_take = s_axi_awready;
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_take = s_axi_arvalid && s_axi_arready;

    // write side registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= 32'h0000_0000;
            serial_cfg <= 32'h0000_0000;
            for (int w = 0; w < 4; w++) begin
                serial_buf[w] <= 32'h0000_0000;
            end
        end else if (wr_take) begin
            if (s_axi_awaddr == ADDR_CTRL) begin
                ctrl_reg <= merge_strb(ctrl_reg, s_axi_wdata, s_axi_wstrb);
            end
            if (s_axi_awaddr == ADDR_SERIAL_CFG) begin
                serial_cfg <= merge_strb(serial_cfg, s_axi_wdata, s_axi_wstrb);
            end
            if (s_axi_awaddr >= ADDR_SERIAL0 && s_axi_awaddr <= ADDR_SERIAL3 && s_axi_awaddr[1:0] == 2'b00) begin
                serial_buf[2'(s_axi_awaddr[7:2] - 6'h02)] <=
                    merge_strb(serial_buf[2'(s_axi_awaddr[7:2] - 6'h02)], s_axi_wdata, s_axi_wstrb);
            end
        end
    end

    // write response
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end else if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (s_axi_awaddr[1:0] == 2'b00 && s_axi_awaddr <= ADDR_RESV) ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read data; status and reservation views show live state
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= AXI_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= AXI_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            case (s_axi_araddr)
                ADDR_CTRL: s_axi_rdata <= {23'h0, ctrl_reg[CTRL_FILL_BIT], 5'h0, cfg_lun};
                ADDR_SERIAL_CFG: s_axi_rdata <= {18'h0, ser_width, 3'h0, ser_len[4:0]};
                8'h08, 8'h0c, 8'h10, ADDR_SERIAL3: s_axi_rdata <= serial_buf[2'(s_axi_araddr[7:2] - 6'h02)];
                ADDR_RESV: begin
                    for (int r = 0; r < NUM_RESV; r++) begin
                        s_axi_rdata[r] <= resv[r].valid;
                    end
                end
                ADDR_STATUS: begin
                    s_axi_rdata[STAT_BUSY_BIT] <= (state != ST_IDLE);
                    for (int s = 0; s < NUM_SLOTS; s++) begin
                        s_axi_rdata[s] <= sense_mem[s].pending;
                    end
                end
                default: s_axi_rresp <= AXI_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// ==== design/srh_pkg.sv ====
// constants, field layouts and carrier types of the sense and release handler
// assumes one 50 MHz clock domain and a 32-bit AXI4-Lite register bus
package srh_pkg;
    // ----
    // command decoding
    // ----
    localparam logic [7:0] OP_RELEASE = 8'h17;
    localparam logic [7:0] OP_SENSE = 8'h03;
    localparam int CDB_LUN_LSB = 5;
    localparam int CDB_ON_BEHALF_BIT = 4;
    localparam int CDB_ON_BEHALF_ID_LSB = 1;
    localparam int CDB_ELEMENT_BIT = 0;
    localparam int NUM_SLOTS = 9;
    localparam logic [3:0] SHARED_SLOT = 4'h8;
    localparam int NUM_RESV = 8;

    // ----
    // sense record layout and values
    // ----
    localparam logic [5:0] SENSE_LEN = 6'h12;
    localparam logic [7:0] RESP_CURRENT = 8'h70;
    localparam logic [7:0] RESP_NONE = 8'h00;
    localparam logic [7:0] ADD_SENSE_LEN = 8'h0a;
    localparam logic [3:0] KEY_NONE = 4'h0;
    localparam logic [3:0] KEY_ILLEGAL = 4'h5;
    localparam logic [3:0] KEY_ABORTED = 4'hb;
    localparam logic [7:0] CODE_NO_LUN = 8'h25;
    localparam logic [7:0] CODE_ZERO = 8'h00;
    localparam logic [7:0] FILL_ZERO = 8'h00;
    localparam logic [7:0] FILL_SPACE = 8'h20;
    localparam logic [5:0] SB_RESP = 6'h00;
    localparam logic [5:0] SB_KEY = 6'h02;
    localparam logic [5:0] SB_ADD_LEN = 6'h07;
    localparam logic [5:0] SB_CODE = 6'h0c;
    localparam logic [5:0] SB_QUAL = 6'h0d;
    localparam logic [5:0] SB_SKS0 = 6'h0f;
    localparam logic [5:0] SB_SKS1 = 6'h10;
    localparam logic [5:0] SB_SKS2 = 6'h11;
    localparam logic [7:0] STATUS_GOOD = 8'h00;

    // ----
    // register map
    // ----
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SERIAL_CFG = 8'h04;
    localparam logic [7:0] ADDR_SERIAL0 = 8'h08;
    localparam logic [7:0] ADDR_SERIAL3 = 8'h14;
    localparam logic [7:0] ADDR_RESV = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1c;
    localparam int CTRL_LUN_LSB = 0;
    localparam int CTRL_FILL_BIT = 8;
    localparam int SER_LEN_LSB = 0;
    localparam int SER_WIDTH_LSB = 8;
    localparam int RESV_IDX_LSB = 0;
    localparam int RESV_OWNER_LSB = 3;
    localparam int RESV_OB_BIT = 6;
    localparam int RESV_OB_ID_LSB = 7;
    localparam int RESV_VALID_BIT = 15;
    localparam int STAT_BUSY_BIT = 16;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    // ----
    // carrier types
    // ----
    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte1;
        logic [7:0] byte2;
        logic [7:0] alloc_len;
        logic [2:0] initiator;
        logic id_known;
    } srh_cmd_t;

    typedef struct packed {
        logic cd;
        logic bpv;
        logic [2:0] bit_ptr;
        logic [15:0] field_ptr;
    } srh_sks_t;

    typedef struct packed {
        logic pending;
        logic [3:0] key;
        logic [7:0] additional_code;
        logic [7:0] additional_qualifier;
        srh_sks_t sks;
    } srh_sense_t;

    typedef struct packed {
        logic [3:0] key;
        logic [7:0] additional_code;
        logic [7:0] additional_qualifier;
        srh_sks_t sks;
        logic [2:0] initiator;
        logic id_known;
    } srh_err_t;

    typedef struct packed {
        logic valid;
        logic [2:0] owner;
        logic on_behalf_flag;
        logic [2:0] on_behalf_id;
    } srh_resv_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SENSE = 2'b01,
        ST_SERIAL = 2'b10,
        ST_STATUS = 2'b11
    } srh_state_t;
endpackage

// ==== verif/srh_chk.sv ====
// port checker for srh_top
// bound onto srh_top, one clock domain
`timescale 1ns/1ps
module srh_chk (
    // watched ports
    input wire logic i_clk, i_rst_n, i_cmd_valid, o_cmd_ready, o_status_valid,
    input wire logic o_byte_valid, o_byte_last, i_byte_ready,
    input wire logic [7:0] o_status, o_byte_data,
    input wire srh_pkg::srh_cmd_t i_cmd
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // a command taken, and a sense command with a given length
    sequence s_take(logic [7:0] op); i_cmd_valid && o_cmd_ready && i_cmd.opcode == op; endsequence
    sequence s_sns(logic [7:0] n); s_take(8'h03) ##0 i_cmd.alloc_len == n; endsequence
    property p_good; o_status_valid |-> o_status == 8'h00; endproperty
    a_good: assert property (p_good) else $error("status not good");
    property p_rel; s_take(8'h17) |-> ##2 o_status_valid; endproperty
    a_rel: assert property (p_rel) else $error("release status late");
    property p_relq; s_take(8'h17) |=> !o_byte_valid [*2]; endproperty
    a_relq: assert property (p_relq) else $error("release sent bytes");
    property p_zero; s_sns(8'h00) |=> !o_byte_valid ##1 o_status_valid; endproperty
    a_zero: assert property (p_zero) else $error("zero length sent bytes");
    property p_one; s_sns(8'h01) |=> o_byte_valid && o_byte_last; endproperty
    a_one: assert property (p_one) else $error("one byte not last");
    property p_more; s_sns(8'h14) |=> o_byte_valid && !o_byte_last; endproperty
    a_more: assert property (p_more) else $error("long sense ended early");
    property p_hold; o_byte_valid && !i_byte_ready |=> o_byte_valid && $stable(o_byte_data); endproperty
    a_hold: assert property (p_hold) else $error("byte dropped while stalled");
    property p_busy; s_take(8'h03) |=> !o_cmd_ready; endproperty
    a_busy: assert property (p_busy) else $error("ready while busy");
endmodule
bind srh_top srh_chk u_chk (.*);

// ==== verif/srh_sink.sv ====
// byte sink in the initiator's place
// one clock; stalls one cycle in three so held bytes are seen
`timescale 1ns/1ps
module srh_sink (
    // stream in
    input wire logic i_clk,
    input wire logic i_valid,
    input wire logic [7:0] i_data,
    output logic o_ready
);
    logic [7:0] q[$];
    logic [1:0] cnt = 2'h0;
    // count the stall pattern and keep every byte taken
    always @(posedge i_clk) begin
        cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
        if (i_valid && o_ready) q.push_back(i_data);
    end
    assign o_ready = cnt != 2'h0;
endmodule

// ==== verif/sense_and_release_handler_test.sv ====
// self-checking bench for srh_top
// srh_sink takes every byte of the stream
`timescale 1ns/1ps
module sense_and_release_handler_test;
    logic i_clk = '0, i_rst_n = '0, i_cmd_valid = '0, i_err_valid = '0, i_bus_free_valid = '0;
    logic i_bus_free_id_known = '0, i_device_reset_msg = '0, i_bus_reset = '0, i_desc_start = '0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
    logic [2:0] i_bus_free_initiator = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, o_status, o_byte_data;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    srh_pkg::srh_cmd_t i_cmd = '0;
    srh_pkg::srh_err_t i_err = '0;
    logic o_cmd_ready, o_status_valid, o_desc_ready, o_byte_valid, o_byte_last, i_byte_ready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int failures = 0, n_tests = 0;
    srh_top DUT (.*);
    srh_sink u_sink (.i_clk, .i_valid(o_byte_valid), .i_data(o_byte_data), .o_ready(i_byte_ready));
    always #10 i_clk = ~i_clk;
    task automatic chk(input string nm, input logic [31:0] s, e);
        n_tests++;
        if (s !== e) begin failures++; $display("mismatch %s expected %h seen %h", nm, e, s); end
    endtask
    // bus tasks hold each request until its ready is sampled high
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk); s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1; s_axi_bready <= 1'h1;
        do @(posedge i_clk); while (!s_axi_awready);
        s_axi_awvalid <= 1'h0; s_axi_wvalid <= 1'h0;
        do @(posedge i_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [9:0] e);
        @(posedge i_clk); s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1;
        do @(posedge i_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge i_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'h0; chk(nm, {22'h0, s_axi_rresp, s_axi_rdata[7:0]}, {22'h0, e});
    endtask
    // id bit 3 set means no identity given at selection
    task automatic cmd(input logic [7:0] op, b1, b2, n, input logic [3:0] id);
        @(posedge i_clk); u_sink.q.delete();
        i_cmd <= '{op, b1, b2, n, id[2:0], !id[3]}; i_cmd_valid <= 1'h1;
        do @(posedge i_clk); while (!o_cmd_ready);
        i_cmd_valid <= 1'h0;
        do @(posedge i_clk); while (!o_status_valid);
    endtask
    task automatic err(input logic [3:0] id, k, input logic [7:0] c);
        @(posedge i_clk); i_err <= '{k, c, 8'h00, '0, id[2:0], !id[3]}; i_err_valid <= 1'h1;
        @(posedge i_clk); i_err_valid <= 1'h0;
    endtask
    task automatic sense(input logic [7:0] b1, n, input logic [3:0] id, input logic [7:0] r0, k, c);
        logic [7:0] e[18];
        cmd(8'h03, b1, 8'h00, n, id);
        e = '{default: 8'h00};
        e[0] = r0; e[2] = k; e[7] = 8'h0a; e[12] = c; e[15] = (k == 8'h05) ? 8'h80 : 8'h00;
        chk("count", 32'(u_sink.q.size()), (n > 8'h12) ? 32'h12 : {24'h0, n});
        foreach (u_sink.q[i]) chk("byte", u_sink.q[i], e[i]);
    endtask
    task automatic t_sense;
        sense(8'h00, 8'h00, 4'h2, 8'h00, 8'h00, 8'h00);
        sense(8'h00, 8'h12, 4'h2, 8'h00, 8'h00, 8'h00);
        err(4'h3, 4'h4, 8'h44); err(4'h3, 4'h5, 8'h24);
        sense(8'h00, 8'h12, 4'h4, 8'h00, 8'h00, 8'h00);
        sense(8'h00, 8'h14, 4'h3, 8'h70, 8'h05, 8'h24);
        sense(8'h00, 8'h01, 4'h3, 8'h00, 8'h00, 8'h00);
        $display("done sense");
    endtask
    task automatic t_shared;
        @(posedge i_clk); i_bus_free_initiator <= 3'h1; i_bus_free_valid <= 1'h1;
        @(posedge i_clk); i_bus_free_valid <= 1'h0;
        sense(8'h00, 8'h03, 4'h9, 8'h70, 8'h0b, 8'h00);
        err(4'h1, 4'h6, 8'h29);
        @(posedge i_clk); i_device_reset_msg <= 1'h1;
        @(posedge i_clk); i_device_reset_msg <= 1'h0;
        sense(8'h00, 8'h12, 4'h1, 8'h00, 8'h00, 8'h00);
        err(4'h2, 4'h6, 8'h29); i_bus_reset <= 1'h1; repeat (6) @(posedge i_clk);
        i_bus_reset <= 1'h0; repeat (6) @(posedge i_clk);
        sense(8'h00, 8'h12, 4'h2, 8'h00, 8'h00, 8'h00);
        $display("done shared");
    endtask
    task automatic t_lun;
        wr(8'h00, 32'h1); rchk("ctrl", 8'h00, 10'h001);
        sense(8'h00, 8'h10, 4'h5, 8'h70, 8'h05, 8'h25);
        sense(8'h20, 8'h12, 4'h5, 8'h00, 8'h00, 8'h00);
        rchk("unmapped", 8'h40, 10'h200);
        wr(8'h00, 32'h0);
        $display("done lun");
    endtask
    task automatic t_ser;
        wr(8'h08, 32'h64636261); wr(8'h04, 32'h503);
        for (int f = 0; f < 2; f++) begin
            wr(8'h00, {23'h0, f[0], 8'h0}); @(posedge i_clk); u_sink.q.delete(); i_desc_start <= 1'h1;
            do @(posedge i_clk); while (!o_desc_ready);
            i_desc_start <= 1'h0;
            do @(posedge i_clk); while (!(o_byte_valid && o_byte_last && i_byte_ready));
            @(posedge i_clk); chk("count", u_sink.q.size(), 32'h5);
            foreach (u_sink.q[i]) chk("serial", u_sink.q[i], (i < 3) ? 32'h61 + i : {26'h0, f[0], 5'h0});
        end
        $display("done serial");
    endtask
    // owners 3,3,4 and 3 on behalf of 6
    task automatic t_rel;
        wr(8'h18, 32'h8018); wr(8'h18, 32'h8019); wr(8'h18, 32'h8022); wr(8'h18, 32'h835b);
        cmd(8'h17, 8'h01, 8'h01, 8'h00, 4'h3); rchk("resv", 8'h18, 10'h00d);
        cmd(8'h17, 8'h00, 8'h00, 8'h00, 4'h3); rchk("resv", 8'h18, 10'h00c);
        cmd(8'h17, 8'h1c, 8'h00, 8'h00, 4'h3); rchk("resv", 8'h18, 10'h004);
        cmd(8'h17, 8'h00, 8'h00, 8'h00, 4'h3); rchk("resv", 8'h18, 10'h004);
        $display("done release");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'h1;
        t_sense; t_shared; t_lun; t_ser; t_rel;
        tally_and_finish;
    end
    // a few hundred cycles are expected
    initial begin
        #200000;
        failures++;
        tally_and_finish;
    end
endmodule
